// *** rtl/remote_session_responder.sv ***
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
module remote_session_responder #(
  parameter int SecretLen = remote_session_pkg::SECRET_LEN,
  parameter logic [255:0] ProtectMask = remote_session_pkg::PROTECT_MASK,
  parameter int DivLow = remote_session_pkg::DIV_LOW,
  parameter int DivMid = remote_session_pkg::DIV_MID,
  parameter int DivHigh = remote_session_pkg::DIV_HIGH,
  parameter int GapCycles = remote_session_pkg::INTERIM_GAP_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded commands from the frame parser
  input wire logic cmdValid,
  input wire remote_session_pkg::cmd_s cmdIn,
  input wire remote_session_pkg::open_s openIn,
  input wire logic [8*SecretLen-1:0] secretIn,
  output logic cmdReady,
  // Replies to the frame builder
  output logic rspValid,
  output remote_session_pkg::rsp_s rspOut,
  input wire logic rspReady,
  // Command executor
  output logic execStart,
  output remote_session_pkg::cmd_s execCmd,
  input wire logic execValid,
  input wire remote_session_pkg::exec_s execIn,
  output logic execReady,
  // Line rate and session status
  output logic [1:0] rateCode,
  output logic baudTick,
  output logic sessionOpen,
  output logic sessionRestricted
);
  typedef struct packed {
    remote_session_pkg::state_e state;
    remote_session_pkg::state_e after;
    logic rdy;
    logic execGo;
    logic execRdy;
    logic rspValid;
    remote_session_pkg::cmd_s cur;
    remote_session_pkg::rsp_s out;
    remote_session_pkg::rsp_s last;
    logic lastValid;
    logic open;
    logic restricted;
    logic [1:0] rate;
    logic [1:0] pendRate;
    logic rateChange;
    logic nvmInterim;
    logic [22:0] gap;
    logic [12:0] div;
    logic tick;
    logic remotePrev;
    logic [31:0] ctrl;
    logic [31:0] secret;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } st_s;

  st_s st;
  st_s n;
  logic [1:0] rstPipe;
  logic rstSync;
  logic take;
  logic replayHit;
  logic secretSet;
  logic keyZero;
  logic [SecretLen-1:0] byteMatch;
  logic secretMatch;
  logic [7:0] openReason;
  logic [7:0] closeReason;

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  // Unscramble per byte; a plain key XOR stands in for the table scheme
  genvar gi;
  generate
    for (gi = 0; gi < SecretLen; gi++) begin : gSecret
      assign byteMatch[gi] = ((secretIn[8*gi +: 8] ^ openIn.key) == st.secret[8*gi +: 8]);
    end
  endgenerate
  assign secretMatch = &byteMatch;

  // Command intake decisions
  // Parser drops bad frames silently, so only clean commands arrive
  assign take = cmdValid && st.rdy && (st.state == remote_session_pkg::ST_IDLE);
  assign replayHit = st.lastValid && (cmdIn.seq == st.last.seq);
  assign secretSet = st.ctrl[remote_session_pkg::CTRL_SECRET_SET_BIT];
  assign keyZero = (openIn.key == 8'h00);

  // Open-link checks, first failure wins
  always_comb begin
    openReason = remote_session_pkg::REASON_NONE;
    if (cmdIn.item != 8'h00) begin
      openReason = remote_session_pkg::REASON_BAD_ITEM;
    end else if (cmdIn.index != 8'h00) begin
      openReason = remote_session_pkg::REASON_BAD_INDEX;
    end else if (cmdIn.size != remote_session_pkg::OPEN_FIXED_BYTES + 16'(SecretLen)) begin
      openReason = remote_session_pkg::REASON_BAD_LENGTH;
    end else if (openIn.version != remote_session_pkg::PROTOCOL_VERSION) begin
      openReason = remote_session_pkg::REASON_BAD_VALUE;
    end else if (openIn.rate > remote_session_pkg::RATE_CODE_MAX) begin
      openReason = remote_session_pkg::REASON_BAD_VALUE;
    end else if (secretSet && !keyZero && !secretMatch) begin
      openReason = remote_session_pkg::REASON_BAD_SECRET;
    end
  end

  // Close-link checks
  always_comb begin
    closeReason = remote_session_pkg::REASON_NONE;
    if (cmdIn.item != 8'h00) begin
      closeReason = remote_session_pkg::REASON_BAD_ITEM;
    end else if (cmdIn.index != 8'h00) begin
      closeReason = remote_session_pkg::REASON_BAD_INDEX;
    end else if (cmdIn.size != 16'h0000) begin
      closeReason = remote_session_pkg::REASON_BAD_LENGTH;
    end
  end

  function automatic logic [12:0] divFor(input logic [1:0] rate);
    logic [12:0] d;
    case (rate)
      remote_session_pkg::RATE_19200: d = 13'(DivMid - 1);
      remote_session_pkg::RATE_28800: d = 13'(DivHigh - 1);
      default: d = 13'(DivLow - 1);
    endcase
    return d;
  endfunction

  function automatic remote_session_pkg::rsp_s negReply(input logic [7:0] seq,
                                                        input logic [7:0] reason);
    remote_session_pkg::rsp_s r;
    r.seq = seq;
    r.code = remote_session_pkg::NEGATIVE_REPLY;
    r.size = remote_session_pkg::REASON_BYTES;
    r.data = reason;
    return r;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    n = st;
    n.execGo = 1'b0;
    n.tick = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // APB: one wait state, answer registered
    if (psel && penable && !st.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h00000000;
      case (paddr)
        remote_session_pkg::CTRL_OFFSET: begin
          n.prdata = st.ctrl;
          if (pwrite) begin
            n.ctrl = pwdata & remote_session_pkg::CTRL_WRITE_MASK;
          end
        end
        remote_session_pkg::SECRET_OFFSET: begin
          n.prdata = st.secret;
          if (pwrite) begin
            n.secret = pwdata;
          end
        end
        remote_session_pkg::STATUS_OFFSET: begin
          n.prdata[remote_session_pkg::STATUS_OPEN_BIT] = st.open;
          n.prdata[remote_session_pkg::STATUS_RESTRICTED_BIT] = st.restricted;
          n.prdata[remote_session_pkg::STATUS_RATE_LSB +: 2] = st.rate;
          n.prdata[remote_session_pkg::STATUS_BUSY_BIT] =
            (st.state != remote_session_pkg::ST_IDLE);
        end
        remote_session_pkg::LAST_OFFSET: begin
          n.prdata[23:0] = {st.last.seq, st.last.code, st.last.data};
          n.prdata[remote_session_pkg::LAST_VALID_BIT] = st.lastValid;
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end
    // Bit-rate divider follows the live rate only
    if (st.div == 13'h0000) begin
      n.tick = 1'b1;
      n.div = divFor(st.rate);
    end else begin
      n.div = st.div - 13'h0001;
    end
    if (st.gap != 23'h000000) begin
      n.gap = st.gap - 23'h000001;
    end
    // Entering remote mode starts clean at the low rate
    n.remotePrev = st.ctrl[remote_session_pkg::CTRL_REMOTE_BIT];
    if (st.ctrl[remote_session_pkg::CTRL_REMOTE_BIT] && !st.remotePrev) begin
      n.rate = remote_session_pkg::RATE_9600;
      n.open = 1'b0;
      n.restricted = 1'b0;
      n.lastValid = 1'b0;
    end
    case (st.state)
      remote_session_pkg::ST_IDLE: begin
        if (take) begin
          n.cur = cmdIn;
          n.state = remote_session_pkg::ST_SEND;
          n.after = remote_session_pkg::ST_IDLE;
          n.rspValid = 1'b1;
          n.rateChange = 1'b0;
          n.out = negReply(cmdIn.seq, remote_session_pkg::REASON_NOT_OPEN);
          if (replayHit) begin
            n.out = st.last;
          end else if (cmdIn.code == remote_session_pkg::OPEN_LINK_COMMAND) begin
            if (openReason != remote_session_pkg::REASON_NONE) begin
              n.out = negReply(cmdIn.seq, openReason);
            end else begin
              n.out = '{cmdIn.seq, remote_session_pkg::FINAL_ACKNOWLEDGE, 16'h0000, 8'h00};
              n.open = 1'b1;
              n.restricted = secretSet && keyZero;
              n.pendRate = openIn.rate[1:0];
              n.rateChange = 1'b1;
            end
          end else if (!st.open) begin
            n.out = negReply(cmdIn.seq, remote_session_pkg::REASON_NOT_OPEN);
          end else if (cmdIn.code == remote_session_pkg::CLOSE_LINK_COMMAND) begin
            if (closeReason != remote_session_pkg::REASON_NONE) begin
              n.out = negReply(cmdIn.seq, closeReason);
            end else begin
              n.out = '{cmdIn.seq, remote_session_pkg::FINAL_ACKNOWLEDGE, 16'h0000, 8'h00};
              n.open = 1'b0;
              n.restricted = 1'b0;
              n.pendRate = remote_session_pkg::RATE_9600;
              n.rateChange = 1'b1;
            end
          end else if (st.restricted && ProtectMask[cmdIn.code]) begin
            n.out = negReply(cmdIn.seq, remote_session_pkg::REASON_BAD_SECRET);
          end else begin
            // Everything else goes to the executor, which picks its own reasons
            n.rspValid = 1'b0;
            n.state = remote_session_pkg::ST_EXEC;
            n.execGo = 1'b1;
            n.nvmInterim = 1'b0;
          end
        end
      end
      remote_session_pkg::ST_EXEC: begin
        if (execValid && st.execRdy) begin
          if (execIn.nvm && (execIn.code == remote_session_pkg::INTERIM_ACKNOWLEDGE) &&
              st.nvmInterim) begin
            n.state = remote_session_pkg::ST_EXEC; // Extra interim swallowed
          end else begin
            n.out = '{st.cur.seq, execIn.code, execIn.size, execIn.data};
            if (execIn.code == remote_session_pkg::NEGATIVE_REPLY) begin
              n.out.size = remote_session_pkg::REASON_BYTES;
            end
            n.rspValid = 1'b1;
            n.state = remote_session_pkg::ST_SEND;
            n.after = remote_session_pkg::ST_IDLE;
            if (execIn.code == remote_session_pkg::INTERIM_ACKNOWLEDGE) begin
              n.after = remote_session_pkg::ST_EXEC; // Exchange not over yet
              if (execIn.nvm) begin
                n.out.size = 16'h0000;
                n.nvmInterim = 1'b1;
              end
              if (execIn.test) begin
                n.gap = 23'(GapCycles);
              end
            end
          end
        end
      end
      remote_session_pkg::ST_SEND: begin
        if (rspReady) begin
          n.rspValid = 1'b0;
          n.state = st.after;
          n.last = st.out;
          n.lastValid = 1'b1;
          if (st.rateChange) begin
            n.rate = st.pendRate; // Only after the reply left
            n.rateChange = 1'b0;
          end
        end
      end
      default: begin
        n.state = remote_session_pkg::ST_IDLE;
      end
    endcase
    n.rdy = (n.state == remote_session_pkg::ST_IDLE) &&
            n.ctrl[remote_session_pkg::CTRL_REMOTE_BIT] && !n.execGo;
    // Stalls finals too while the test gap runs; at most 100 ms late
    n.execRdy = (n.state == remote_session_pkg::ST_EXEC) && !n.execGo && (n.gap == 23'h000000);
  end

  // All state but the reset synchronizer in one register
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign cmdReady = st.rdy;
  assign rspValid = st.rspValid;
  assign rspOut = st.out;
  assign execStart = st.execGo;
  assign execCmd = st.cur;
  assign execReady = st.execRdy;
  assign rateCode = st.rate;
  assign baudTick = st.tick;
  assign sessionOpen = st.open;
  assign sessionRestricted = st.restricted;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSync);

  sequence s_open_fields_ok;
    take && !replayHit && (cmdIn.code == remote_session_pkg::OPEN_LINK_COMMAND) &&
      (cmdIn.item == 8'h00) && (cmdIn.index == 8'h00) &&
      (cmdIn.size == remote_session_pkg::OPEN_FIXED_BYTES + 16'(SecretLen));
  endsequence

  sequence s_reply_gone;
    rspValid && rspReady;
  endsequence

  a_nak_one_byte: assert property (rspValid && (rspOut.code == remote_session_pkg::NEGATIVE_REPLY)
    |-> rspOut.size == 16'h0001) else $error("negative reply size not one");
  a_no_session: assert property (take && !replayHit && !sessionOpen &&
    (cmdIn.code != remote_session_pkg::OPEN_LINK_COMMAND) |=> rspValid &&
    (rspOut.data == remote_session_pkg::REASON_NOT_OPEN)) else $error("no-session reason missing");
  a_bad_version: assert property (s_open_fields_ok and (openIn.version != 8'h00)
    |=> rspOut.code == 8'h00 && rspOut.data == 8'h08) else $error("bad version accepted");
  a_bad_rate: assert property (s_open_fields_ok and (openIn.version == 8'h00) &&
    (openIn.rate > 8'h02) |=> rspOut.data == 8'h08 && !$changed(rateCode))
    else $error("bad rate code accepted");
  a_rate_after_reply: assert property (rspValid && !rspReady |=> $stable(rateCode) ||
    $past(st.ctrl[0] && !st.remotePrev)) else $error("rate moved before reply left");
  a_rate_switch: assert property (s_reply_gone and st.rateChange |=> rateCode == $past(st.pendRate))
    else $error("rate not switched after reply");
  a_close_drops: assert property (take && !replayHit && sessionOpen &&
    (cmdIn.code == remote_session_pkg::CLOSE_LINK_COMMAND) && (closeReason == 8'h00)
    |=> !sessionOpen ##0 (s_reply_gone or (rspValid && st.pendRate == 2'h0)))
    else $error("close did not drop session");
  a_replay_same: assert property (take && replayHit |=> rspValid && rspOut == $past(st.last))
    else $error("replay reply differs");
  a_nvm_interim: assert property (rspValid && st.nvmInterim &&
    (rspOut.code == remote_session_pkg::INTERIM_ACKNOWLEDGE) |-> rspOut.size == 16'h0000)
    else $error("nonvolatile interim not empty");
  a_exec_open: assert property (execStart |-> sessionOpen && !rspValid ##1
    (execReady || (st.gap != 23'h000000))) else $error("executor started without session");
  a_test_gap: assert property (execValid && execReady && execIn.test &&
    (execIn.code == 8'h02) |=> !execReady[*8]) else $error("test interims too close");
endmodule

// *** shared/remote_session_pkg.sv ***
package remote_session_pkg;
  localparam int CLK_HZ = 50_000_000;
  // Reply codes
  localparam logic [7:0] NEGATIVE_REPLY = 8'h00;
  localparam logic [7:0] FINAL_ACKNOWLEDGE = 8'h01;
  localparam logic [7:0] INTERIM_ACKNOWLEDGE = 8'h02;
  // Reason codes
  localparam logic [7:0] REASON_NOT_OPEN = 8'h01;
  localparam logic [7:0] REASON_BAD_SECRET = 8'h02;
  localparam logic [7:0] REASON_UNKNOWN_OPCODE = 8'h03;
  localparam logic [7:0] REASON_BAD_ITEM = 8'h04;
  localparam logic [7:0] REASON_BAD_INDEX = 8'h05;
  localparam logic [7:0] REASON_TYPE_MISMATCH = 8'h06;
  localparam logic [7:0] REASON_BAD_LENGTH = 8'h07;
  localparam logic [7:0] REASON_BAD_VALUE = 8'h08;
  localparam logic [7:0] REASON_WRITE_PROTECTED = 8'h09;
  localparam logic [7:0] REASON_UNIMPLEMENTED = 8'h0a;
  localparam logic [7:0] REASON_OUT_OF_ORDER = 8'h0b;
  localparam logic [7:0] REASON_NO_SPACE = 8'h0c;
  localparam logic [7:0] REASON_NVM_FAULT = 8'h0d;
  localparam logic [7:0] REASON_NONE = 8'h00;
  // Commands handled here
  localparam logic [7:0] OPEN_LINK_COMMAND = 8'h10;
  localparam logic [7:0] CLOSE_LINK_COMMAND = 8'h11;
  localparam logic [7:0] PROTOCOL_VERSION = 8'h00;
  localparam logic [7:0] RATE_CODE_MAX = 8'h02;
  localparam logic [15:0] OPEN_FIXED_BYTES = 16'h0003;
  localparam logic [15:0] REASON_BYTES = 16'h0001;
  localparam int SECRET_LEN = 4;
  // Set commands 0x21, 0x23, 0x25, 0x27 need an unrestricted session
  localparam logic [255:0] PROTECT_MASK = 256'h000000aa_00000000;
  // Line rates
  localparam logic [1:0] RATE_9600 = 2'h0;
  localparam logic [1:0] RATE_19200 = 2'h1;
  localparam logic [1:0] RATE_28800 = 2'h2;
  localparam int BAUD_LOW = 9600;
  localparam int BAUD_MID = 19200;
  localparam int BAUD_HIGH = 28800;
  localparam int DIV_LOW = CLK_HZ / BAUD_LOW;
  localparam int DIV_MID = CLK_HZ / BAUD_MID;
  localparam int DIV_HIGH = CLK_HZ / BAUD_HIGH;
  // Test interim spacing: ten per second at most
  localparam int INTERIM_GAP_MS = 100;
  localparam int INTERIM_GAP_CYCLES = (CLK_HZ / 1000) * INTERIM_GAP_MS;
  // APB map
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] SECRET_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam logic [11:0] LAST_OFFSET = 12'h00c;
  localparam int CTRL_REMOTE_BIT = 0;
  localparam int CTRL_SECRET_SET_BIT = 1;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h00000003;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] SECRET_RESET = 32'h00000000;
  localparam int STATUS_OPEN_BIT = 0;
  localparam int STATUS_RESTRICTED_BIT = 1;
  localparam int STATUS_RATE_LSB = 2;
  localparam int STATUS_BUSY_BIT = 4;
  localparam int LAST_VALID_BIT = 24;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SEND = 2'b11
  } state_e;

  typedef struct packed {
    logic [7:0] seq;
    logic [7:0] code;
    logic [7:0] item;
    logic [7:0] index;
    logic [15:0] size;
  } cmd_s;

  typedef struct packed {
    logic [7:0] version;
    logic [7:0] rate;
    logic [7:0] key;
  } open_s;

  typedef struct packed {
    logic [7:0] seq;
    logic [7:0] code;
    logic [15:0] size;
    logic [7:0] data;
  } rsp_s;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] size;
    logic [7:0] data;
    logic nvm;
    logic test;
  } exec_s;
endpackage

// *** tb/host_model.sv ***
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic ref_clk,
  // Command side
  input wire logic cmdReady,
  output logic cmdValid,
  output remote_session_pkg::cmd_s cmdIn,
  output remote_session_pkg::open_s openIn,
  output logic [31:0] secretIn,
  // Reply side
  input wire logic rspValid,
  input wire remote_session_pkg::rsp_s rspOut,
  output logic rspReady
);
  remote_session_pkg::rsp_s got[$];
  initial begin
    cmdValid = 1'b0;
    cmdIn = '0;
    openIn = '0;
    secretIn = '0;
  end
  // Replies taken with random stalls, as a slow host would
  always @(posedge ref_clk) begin
    if (rspValid && rspReady) begin
      got.push_back(rspOut);
    end
    rspReady <= ($urandom_range(0, 3) != 0);
  end
  // Whole command held until taken; released fields are inverted so stale data shows
  // Only frames that passed the parser's checks reach this level
  task automatic send(input remote_session_pkg::cmd_s c, input remote_session_pkg::open_s o,
                      input logic [31:0] s);
    cmdValid <= 1'b1;
    cmdIn <= c;
    openIn <= o;
    secretIn <= s;
    do @(posedge ref_clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    cmdIn <= ~c;
    openIn <= ~o;
    secretIn <= ~s;
  endtask
endmodule

// *** tb/remote_session_responder_bench.sv ***
`timescale 1ns/100ps
module remote_session_responder_bench;
  localparam logic [15:0] OpenLen = 16'(3 + remote_session_pkg::SECRET_LEN);
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, secretIn, rd, sec;
  logic cmdValid, cmdReady, rspValid, rspReady, execStart, execValid, execReady;
  logic baudTick, sessionOpen, sessionRestricted;
  logic [1:0] rateCode;
  logic [7:0] seq = 8'h00;
  logic [7:0] k;
  logic [7:0] why [5] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h08};
  remote_session_pkg::cmd_s cmdIn, execCmd;
  remote_session_pkg::open_s openIn;
  remote_session_pkg::rsp_s rspOut, r;
  remote_session_pkg::exec_s execIn, plan[$];
  int n_mismatch = 0, compares = 0, cycles = 0, ticks;
  remote_session_responder #(.DivLow(8), .DivMid(4), .DivHigh(3), .GapCycles(20))
  i_remote_session_responder (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmdValid(cmdValid), .cmdIn(cmdIn), .openIn(openIn),
    .secretIn(secretIn), .cmdReady(cmdReady), .rspValid(rspValid), .rspOut(rspOut),
    .rspReady(rspReady), .execStart(execStart), .execCmd(execCmd), .execValid(execValid),
    .execIn(execIn), .execReady(execReady), .rateCode(rateCode), .baudTick(baudTick),
    .sessionOpen(sessionOpen), .sessionRestricted(sessionRestricted));
  host_model i_host_model (.ref_clk(ref_clk), .cmdReady(cmdReady), .cmdValid(cmdValid),
    .cmdIn(cmdIn), .openIn(openIn), .secretIn(secretIn), .rspValid(rspValid),
    .rspOut(rspOut), .rspReady(rspReady));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Executor stand-in answers from a plan; a long count here means a hang
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
    if (execValid && execReady) begin
      execValid <= 1'b0;
      execIn <= ~execIn;
    end else if (!execValid && execReady && plan.size() > 0) begin
      execValid <= 1'b1;
      execIn <= plan.pop_front();
    end
  end
  task automatic summarize();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] it, input logic [7:0] ix,
                    input logic [15:0] sz, input logic [23:0] o, input logic [31:0] s);
    seq = seq + 8'h01;
    i_host_model.send({seq, c, it, ix, sz}, o, s);
  endtask
  // Empty replies are judged on header only
  task automatic want(input logic [7:0] c, input logic [15:0] sz, input logic [7:0] d);
    // Bounded wait for the next reply, interim or final, as a patient host would
    for (int i = 0; i < 400 && i_host_model.got.size() == 0; i++) @(posedge ref_clk);
    r = (i_host_model.got.size() > 0) ? i_host_model.got.pop_front() : '1;
    check((sz == 0) ? r[39:8] : r, (sz == 0) ? {seq, c, sz} : {seq, c, sz, d});
  endtask
  task automatic settle(input logic [3:0] exp, input int div);
    // The divider finishes its old-rate count first, so wait out the slowest one
    repeat (10) @(posedge ref_clk);
    check({sessionOpen, sessionRestricted, rateCode}, exp);
    ticks = 0;
    repeat (24) begin
      @(posedge ref_clk);
      if (baudTick === 1'b1) ticks++;
    end
    check(ticks, 24 / div);
  endtask
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, execValid, execIn} = '0;
    k = 8'($urandom(32'he1a2476c));
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check({sessionOpen, rateCode}, 3'b000);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check({er, rd}, 33'h100000000);
    apb(1'b1, 12'h000, 32'h1);
    go(8'h22, 0, 0, 0, 0, 0);
    want(8'h00, 1, 8'h01);
    go(8'h11, 0, 0, 0, 0, 0);
    want(8'h00, 1, 8'h01);
    // Broken opens, one field wrong at a time
    for (int i = 0; i < 5; i++) begin
      go(8'h10, 8'(i == 0), 8'(i == 1), (i == 2) ? 16'h6 : OpenLen,
         {8'(i == 3), (i == 4) ? 8'h03 : 8'h01, 8'h00}, 0);
      want(8'h00, 1, why[i]);
    end
    go(8'h10, 0, 0, OpenLen, 24'h000100, $urandom); // First try at the low rate
    check(rateCode, 2'h0);
    want(8'h01, 0, 0);
    settle(4'b1001, 4);
    i_host_model.send({seq, 8'h10, 16'h0, OpenLen}, 24'h000200, 0);
    want(8'h01, 0, 0);
    settle(4'b1001, 4);
    plan = '{{8'h02, 16'h5, 8'h5a, 2'b10}, {8'h02, 16'h3, 8'h11, 2'b10},
             {8'h01, 16'h1, 8'h3c, 2'b00}, {8'h02, 16'h1, 8'h77, 2'b01},
             {8'h01, 16'h1, 8'h42, 2'b00}};
    go(8'h22, 0, 0, 0, 0, 0);
    want(8'h02, 0, 0);
    want(8'h01, 1, 8'h3c);
    go(8'h24, 0, 0, 0, 0, 0);
    want(8'h02, 1, 8'h77);
    want(8'h01, 1, 8'h42);
    for (int c = 3; c <= 13; c++) begin
      k = 8'(c);
      plan.push_back({8'h00, 16'($urandom_range(0, 9)), k, 2'b00});
      go(8'h22 + 8'(2 * $urandom_range(0, 2)), 0, 0, 0, 0, 0);
      want(8'h00, 1, k);
    end
    sec = $urandom;
    apb(1'b1, 12'h004, sec);
    apb(1'b1, 12'h000, 32'h3);
    go(8'h10, 0, 0, OpenLen, 24'h000100, ~sec);
    want(8'h01, 0, 0);
    settle(4'b1101, 4);
    go(8'h21 + 8'(2 * $urandom_range(0, 3)), 0, 0, 0, 0, 0);
    want(8'h00, 1, 8'h02);
    k = 8'($urandom_range(1, 255));
    go(8'h10, 0, 0, OpenLen, {16'h0002, k}, sec ^ {4{k}} ^ 32'h100);
    want(8'h00, 1, 8'h02);
    go(8'h10, 0, 0, OpenLen, {16'h0002, k}, sec ^ {4{k}});
    want(8'h01, 0, 0);
    settle(4'b1010, 3);
    go(8'h11, 0, 0, 16'h1, 0, 0);
    want(8'h00, 1, 8'h07);
    go(8'h11, 0, 0, 0, 0, 0);
    want(8'h01, 0, 0);
    settle(4'b0000, 8);
    summarize();
  end
endmodule
